// ===== verilog/nch_defs.svh
// constants for the nand command host
`ifndef NCH_DEFS_SVH
`define NCH_DEFS_SVH
`define NCH_CMD_READ 8'h00
`define NCH_CMD_READ_GO 8'h30
`define NCH_CMD_PROG_CONF 8'h10
`define NCH_CMD_MPROG_CONF 8'h11
`define NCH_CMD_SDIN 8'h80
`define NCH_CMD_COLCHG 8'h85
`define NCH_CMD_ERASE 8'h60
`define NCH_CMD_ERASE_CONF 8'hd0
`define NCH_CMD_STATUS 8'h70
`define NCH_CMD_STATUS2 8'h71
`define NCH_CMD_ECCSTAT 8'h7a
`define NCH_CMD_RESET 8'hff
`define NCH_A_CTRL 4'h0
`define NCH_A_ADDR 4'h1
`define NCH_A_DATA 4'h2
`define NCH_A_STAT 4'h3
`define NCH_A_IRQ 4'h4
`define NCH_A_MASK 4'h5
`define NCH_A_SECT 4'h6
`define NCH_A_CNT 4'h7
`define NCH_OP_NONE 3'h0
`define NCH_OP_CMD 3'h1
`define NCH_OP_ADDR 3'h2
`define NCH_OP_WDATA 3'h3
`define NCH_OP_RDATA 3'h4
`define NCH_OP_ECC 3'h5
`define NCH_SECTORS 3'h4
`define NCH_ECC_UNCORR 4'hf
`define NCH_ECC_MAXCORR 4'h8
`define NCH_ST_FAIL 0
`define NCH_ST_RDY 6
`define NCH_ST_WP 7
`define NCH_ADDR_CYC 3'h5
`define NCH_PP_MAX 3'h4
`define NCH_BLK_MIN 12'd2008
`define NCH_IRQ_W 4
`define NCH_IRQ_DONE 0
`define NCH_IRQ_REFUSE 1
`define NCH_IRQ_UNCORR 2
`define NCH_IRQ_RDY 3
`endif

// ===== verilog/nch_pkg.sv
// types for the nand command host
package nch_pkg;
  typedef enum logic [4:0] {
    NCH_IDLE = 5'b00001,
    NCH_SETUP = 5'b00010,
    NCH_STROBE = 5'b00100,
    NCH_HOLD = 5'b01000,
    NCH_CAPT = 5'b10000
  } nch_state_t;
endpackage

// ===== verilog/nch_sync.sv
// two flip-flop synchroniser
`timescale 1ns/10ps
module nch_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule

// ===== verilog/nch_host.sv
// host controller driving the nand command, address and data strobes
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "nch_defs.svh"
module nch_host import nch_pkg::*; #(
  parameter int STROBE_CYC = 3,
  parameter int BLK_W = 11
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // nand pins
  output logic cle_o,
  output logic ale_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic wp_n_o,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic ready_busy_out_i
);
  logic rb_s;
  logic [7:0] io_s;
  nch_sync #(.W(9)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({ready_busy_out_i, io_i}),
    .q_o({rb_s, io_s})
  );

  // ----------------------------------------
  // pin sequencer
  // ----------------------------------------
  nch_state_t st_ff, nxt_st;
  logic [2:0] op_ff, nxt_op;
  logic [7:0] byte_ff, nxt_byte;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] rdat_ff, nxt_rdat;
  logic [7:0] last_cmd_ff, nxt_last_cmd;
  logic sdin_ff, nxt_sdin;
  logic rdmode_ff, nxt_rdmode;
  logic stmode_ff, nxt_stmode;
  logic [2:0] acyc_ff, nxt_acyc;
  logic [2:0] sect_ff, nxt_sect;
  logic [15:0] sect_bytes_ff, nxt_sect_bytes;
  logic [2:0] pp_cnt_ff, nxt_pp_cnt;
  logic [5:0] last_page_ff, nxt_last_page;
  logic page_seen_ff, nxt_page_seen;
  logic wp_ff, nxt_wp;
  logic bad_ff, nxt_bad;
  logic [`NCH_IRQ_W-1:0] irq_st_ff, nxt_irq_st;
  logic [`NCH_IRQ_W-1:0] mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [5:0] page_ff, nxt_page;
  logic start, legal, allowed, busy;
  logic [`NCH_IRQ_W-1:0] ev;
  logic [7:0] code;

  assign busy = ~rb_s;
  assign code = reg_wdata_i[7:0];

  always_comb begin
    unique case (code)
      `NCH_CMD_READ, `NCH_CMD_READ_GO, `NCH_CMD_PROG_CONF,
      `NCH_CMD_MPROG_CONF, `NCH_CMD_SDIN, `NCH_CMD_COLCHG,
      `NCH_CMD_ERASE, `NCH_CMD_ERASE_CONF, `NCH_CMD_STATUS,
      `NCH_CMD_STATUS2, `NCH_CMD_ECCSTAT, `NCH_CMD_RESET: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // command gating against busy, serial input, page and erase limits
  always_comb begin
    allowed = legal;
    if (busy && !(code == `NCH_CMD_STATUS || code == `NCH_CMD_STATUS2 ||
        code == `NCH_CMD_RESET))
      allowed = 1'b0;
    if (sdin_ff && !(code == `NCH_CMD_COLCHG ||
        code == `NCH_CMD_PROG_CONF || code == `NCH_CMD_MPROG_CONF ||
        code == `NCH_CMD_RESET))
      allowed = 1'b0;
    if ((code == `NCH_CMD_PROG_CONF || code == `NCH_CMD_MPROG_CONF) &&
        page_seen_ff &&
        (page_ff < last_page_ff ||
        (page_ff == last_page_ff && pp_cnt_ff >= `NCH_PP_MAX)))
      allowed = 1'b0;
    if ((code == `NCH_CMD_ERASE || code == `NCH_CMD_ERASE_CONF) && bad_ff)
      allowed = 1'b0;
  end

  assign start = reg_wr_i && st_ff == NCH_IDLE;

  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_byte = byte_ff;
    nxt_cnt = cnt_ff;
    nxt_rdat = rdat_ff;
    nxt_last_cmd = last_cmd_ff;
    nxt_sdin = sdin_ff;
    nxt_rdmode = rdmode_ff;
    nxt_stmode = stmode_ff;
    nxt_acyc = acyc_ff;
    nxt_sect = sect_ff;
    nxt_sect_bytes = sect_bytes_ff;
    nxt_pp_cnt = pp_cnt_ff;
    nxt_last_page = last_page_ff;
    nxt_page_seen = page_seen_ff;
    nxt_wp = wp_ff;
    nxt_bad = bad_ff;
    nxt_mask = mask_ff;
    nxt_page = page_ff;
    ev = '0;
    unique case (st_ff)
      NCH_IDLE: begin
        if (start && reg_addr_i == `NCH_A_CTRL) begin
          if (allowed) begin
            nxt_op = `NCH_OP_CMD;
            nxt_byte = code;
            nxt_st = NCH_SETUP;
          end else begin
            ev[`NCH_IRQ_REFUSE] = 1'b1;
          end
        end else if (start && reg_addr_i == `NCH_A_ADDR) begin
          if (acyc_ff < `NCH_ADDR_CYC) begin
            nxt_op = `NCH_OP_ADDR;
            nxt_byte = reg_wdata_i[7:0];
            nxt_acyc = acyc_ff + 3'h1;
            if (acyc_ff == 3'h2)
              nxt_page = reg_wdata_i[5:0];
            nxt_st = NCH_SETUP;
          end else begin
            ev[`NCH_IRQ_REFUSE] = 1'b1;
          end
        end else if (start && reg_addr_i == `NCH_A_DATA) begin
          nxt_op = reg_wdata_i[8] ? `NCH_OP_RDATA : `NCH_OP_WDATA;
          nxt_byte = reg_wdata_i[7:0];
          nxt_st = NCH_SETUP;
        end else if (start && reg_addr_i == `NCH_A_SECT) begin
          nxt_op = `NCH_OP_ECC;
          nxt_sect = 3'h0;
          nxt_st = NCH_SETUP;
        end else if (start && reg_addr_i == `NCH_A_MASK) begin
          nxt_mask = reg_wdata_i[`NCH_IRQ_W-1:0];
        end else if (start && reg_addr_i == `NCH_A_STAT) begin
          nxt_wp = reg_wdata_i[8];
          nxt_bad = reg_wdata_i[9];
        end
      end
      NCH_SETUP: begin
        nxt_cnt = '0;
        nxt_st = NCH_STROBE;
      end
      NCH_STROBE: begin
        nxt_cnt = cnt_ff + 8'h1;
        if (cnt_ff == 8'(STROBE_CYC - 1))
          nxt_st = NCH_CAPT;
      end
      NCH_CAPT: begin
        nxt_st = NCH_HOLD;
        if (op_ff == `NCH_OP_RDATA || op_ff == `NCH_OP_ECC)
          nxt_rdat = io_s;
        if (op_ff == `NCH_OP_CMD) begin
          nxt_last_cmd = byte_ff;
          nxt_acyc = '0;
          if (byte_ff == `NCH_CMD_RESET) begin
            nxt_sdin = 1'b0;
            nxt_rdmode = 1'b0;
            nxt_stmode = 1'b0;
          end
          if (byte_ff == `NCH_CMD_SDIN)
            nxt_sdin = 1'b1;
          if (byte_ff == `NCH_CMD_PROG_CONF ||
              byte_ff == `NCH_CMD_MPROG_CONF) begin
            nxt_sdin = 1'b0;
            nxt_pp_cnt = (page_seen_ff && page_ff == last_page_ff) ?
              pp_cnt_ff + 3'h1 : 3'h1;
            nxt_last_page = page_ff;
            nxt_page_seen = 1'b1;
          end
          if (byte_ff == `NCH_CMD_ERASE_CONF) begin
            nxt_page_seen = 1'b0;
            nxt_pp_cnt = '0;
          end
          if (byte_ff == `NCH_CMD_READ_GO)
            nxt_rdmode = 1'b1;
          // status then 00h resumes read output
          if (byte_ff == `NCH_CMD_STATUS && rdmode_ff)
            nxt_stmode = 1'b1;
          if (byte_ff == `NCH_CMD_READ && stmode_ff)
            nxt_stmode = 1'b0;
        end
      end
      NCH_HOLD: begin
        if (op_ff == `NCH_OP_ECC) begin
          nxt_sect_bytes[{rdat_ff[5:4], 2'b00} +: 4] = rdat_ff[3:0];
          if (rdat_ff[3:0] == `NCH_ECC_UNCORR)
            ev[`NCH_IRQ_UNCORR] = 1'b1;
          nxt_sect = sect_ff + 3'h1;
          nxt_st = (sect_ff == `NCH_SECTORS - 3'h1) ? NCH_IDLE : NCH_SETUP;
        end else begin
          nxt_st = NCH_IDLE;
        end
        if (nxt_st == NCH_IDLE)
          ev[`NCH_IRQ_DONE] = 1'b1;
      end
      default: nxt_st = NCH_IDLE;
    endcase
  end

  // sticky status, set wins over clear
  always_comb begin
    nxt_irq_st = irq_st_ff;
    if (reg_wr_i && reg_addr_i == `NCH_A_IRQ)
      nxt_irq_st = irq_st_ff & ~reg_wdata_i[`NCH_IRQ_W-1:0];
    nxt_irq_st = nxt_irq_st | ev;
  end

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `NCH_A_DATA: nxt_rdata = {24'h0, rdat_ff};
        `NCH_A_STAT: nxt_rdata = {22'h0, bad_ff, wp_ff, rdat_ff[`NCH_ST_WP],
          rdat_ff[`NCH_ST_RDY], rdat_ff[`NCH_ST_FAIL], stmode_ff, sdin_ff,
          st_ff == NCH_IDLE, rdmode_ff, rb_s};
        `NCH_A_IRQ: nxt_rdata = {28'h0, irq_st_ff};
        `NCH_A_MASK: nxt_rdata = {28'h0, mask_ff};
        `NCH_A_SECT: nxt_rdata = {16'h0, sect_bytes_ff};
        `NCH_A_CNT: nxt_rdata = {16'h0, last_cmd_ff, 2'h0, last_page_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= NCH_IDLE;
      op_ff <= `NCH_OP_NONE;
      byte_ff <= '0;
      cnt_ff <= '0;
      rdat_ff <= '0;
      last_cmd_ff <= '0;
      sdin_ff <= 1'b0;
      rdmode_ff <= 1'b0;
      stmode_ff <= 1'b0;
      acyc_ff <= '0;
      sect_ff <= '0;
      sect_bytes_ff <= '0;
      pp_cnt_ff <= '0;
      last_page_ff <= '0;
      page_seen_ff <= 1'b0;
      wp_ff <= 1'b0;
      bad_ff <= 1'b0;
      irq_st_ff <= '0;
      mask_ff <= '0;
      rdata_ff <= '0;
      page_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      byte_ff <= nxt_byte;
      cnt_ff <= nxt_cnt;
      rdat_ff <= nxt_rdat;
      last_cmd_ff <= nxt_last_cmd;
      sdin_ff <= nxt_sdin;
      rdmode_ff <= nxt_rdmode;
      stmode_ff <= nxt_stmode;
      acyc_ff <= nxt_acyc;
      sect_ff <= nxt_sect;
      sect_bytes_ff <= nxt_sect_bytes;
      pp_cnt_ff <= nxt_pp_cnt;
      last_page_ff <= nxt_last_page;
      page_seen_ff <= nxt_page_seen;
      wp_ff <= nxt_wp;
      bad_ff <= nxt_bad;
      irq_st_ff <= nxt_irq_st;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      page_ff <= nxt_page;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  logic in_strobe;
  assign in_strobe = st_ff == NCH_STROBE;
  assign cle_o = st_ff != NCH_IDLE && op_ff == `NCH_OP_CMD;
  assign ale_o = st_ff != NCH_IDLE && op_ff == `NCH_OP_ADDR;
  assign ce_n_o = st_ff == NCH_IDLE;
  assign we_n_o = ~(in_strobe && (op_ff == `NCH_OP_CMD ||
    op_ff == `NCH_OP_ADDR || op_ff == `NCH_OP_WDATA));
  assign read_strobe_n_o = ~(in_strobe && (op_ff == `NCH_OP_RDATA ||
    op_ff == `NCH_OP_ECC));
  // write protect level steers program and erase
  assign wp_n_o = wp_ff;
  assign io_o = byte_ff;
  assign io_oe_o = st_ff != NCH_IDLE && (op_ff == `NCH_OP_CMD ||
    op_ff == `NCH_OP_ADDR || op_ff == `NCH_OP_WDATA);
  assign reg_rdata_o = rdata_ff;
  assign irq_o = |(irq_st_ff & mask_ff);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_busy_cmd;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff == NCH_SETUP && op_ff == `NCH_OP_CMD && $past(busy)) |->
      (byte_ff == `NCH_CMD_STATUS || byte_ff == `NCH_CMD_STATUS2 ||
       byte_ff == `NCH_CMD_RESET);
  endproperty
  a_busy_cmd: assert property (p_busy_cmd)
    else $error("illegal command sent while busy");
  property p_sdin_follow;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff == NCH_SETUP && op_ff == `NCH_OP_CMD && sdin_ff) |->
      (byte_ff == `NCH_CMD_COLCHG || byte_ff == `NCH_CMD_PROG_CONF ||
       byte_ff == `NCH_CMD_MPROG_CONF || byte_ff == `NCH_CMD_RESET);
  endproperty
  a_sdin_follow: assert property (p_sdin_follow)
    else $error("illegal command after serial input");
  property p_addr_max;
    @(posedge clk_sys_i) disable iff (rst_i)
      acyc_ff <= `NCH_ADDR_CYC;
  endproperty
  a_addr_max: assert property (p_addr_max)
    else $error("more than five address cycles");
  property p_pp_max;
    @(posedge clk_sys_i) disable iff (rst_i)
      pp_cnt_ff <= `NCH_PP_MAX;
  endproperty
  a_pp_max: assert property (p_pp_max)
    else $error("partial program count above four");
  property p_bad_erase;
    @(posedge clk_sys_i) disable iff (rst_i)
      (start && reg_addr_i == `NCH_A_CTRL && bad_ff &&
       (code == `NCH_CMD_ERASE || code == `NCH_CMD_ERASE_CONF)) |=>
      (st_ff == NCH_IDLE && irq_st_ff[`NCH_IRQ_REFUSE]);
  endproperty
  a_bad_erase: assert property (p_bad_erase)
    else $error("erase sent to bad block");
  property p_reset_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff == NCH_CAPT && op_ff == `NCH_OP_CMD &&
       byte_ff == `NCH_CMD_RESET) |=> (!sdin_ff && !stmode_ff);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left state behind");
  property p_ecc_four;
    @(posedge clk_sys_i) disable iff (rst_i)
      (start && reg_addr_i == `NCH_A_SECT) |=> ##[1:60]
      (st_ff == NCH_HOLD && op_ff == `NCH_OP_ECC && sect_ff == 3'h3);
  endproperty
  a_ecc_four: assert property (p_ecc_four)
    else $error("ecc sector read did not finish");
  property p_uncorr;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff == NCH_HOLD && op_ff == `NCH_OP_ECC &&
       rdat_ff[3:0] == `NCH_ECC_UNCORR) |=> irq_st_ff[`NCH_IRQ_UNCORR];
  endproperty
  a_uncorr: assert property (p_uncorr)
    else $error("uncorrectable sector not flagged");
  property p_strobe_len;
    @(posedge clk_sys_i) disable iff (rst_i)
      $fell(we_n_o) |-> (!we_n_o) [*3];
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("write strobe too short");
  c_cmd: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    st_ff == NCH_CAPT && op_ff == `NCH_OP_CMD);
  c_ecc: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    st_ff == NCH_HOLD && op_ff == `NCH_OP_ECC && sect_ff == 3'h3);
  c_refuse: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ev[`NCH_IRQ_REFUSE]);
endmodule

// ===== bench/nch_dev_model.sv
// behavioural nand device answering the host pins
`timescale 1ns/10ps
module nch_dev_model #(
  parameter int PWR_BUSY = 40,
  parameter int RD_BUSY = 10,
  parameter int PE_BUSY = 200
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // nand pins
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic ready_busy_out_o
);
  localparam logic [15:0] ECC_CNT = 16'hf810;
  logic [15:0] busy_ff;
  logic [2:0] acnt_ff;
  logic [11:0] col_ff;
  logic [1:0] sect_ff;
  logic [1:0] mode_ff;
  logic pend_ff, pe_ff, we_ff, rs_ff, rdy;
  logic [7:0] last_ff, cur;

  assign rdy = (busy_ff == 16'h0000);
  assign ready_busy_out_o = rdy;
  // released data lines show the inverse of the last byte
  assign io_o = (!ce_n_i && !read_strobe_n_i) ? cur : ~last_ff;

  always_comb begin
    case (mode_ff)
      2'd1: cur = {wp_n_i, rdy, rdy, 5'h00};
      2'd2: cur = {2'b00, sect_ff, ECC_CNT[{sect_ff, 2'b00} +: 4]};
      default: cur = col_ff[7:0] ^ 8'h5a;
    endcase
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 16'(PWR_BUSY);
      {acnt_ff, col_ff, sect_ff, mode_ff} <= '0;
      {pend_ff, pe_ff, we_ff, rs_ff} <= 4'h3;
      last_ff <= 8'h00;
    end else begin
      we_ff <= we_n_i;
      rs_ff <= read_strobe_n_i;
      if (!rdy) busy_ff <= busy_ff - 16'h0001;
      if (rdy) pe_ff <= 1'b0;
      // write protect low ends program or erase
      if (!wp_n_i && pe_ff) begin
        busy_ff <= 16'h0000;
        pe_ff <= 1'b0;
      end
      if (!we_ff && we_n_i && !ce_n_i) begin
        if (cle_i) begin
          acnt_ff <= 3'h0;
          if (!(io_i inside {8'h85, 8'h10, 8'h11, 8'hff})) pend_ff <= 1'b0;
          case (io_i)
            // read command resumes at held column
            8'h00: mode_ff <= 2'd0;
            8'h30: begin
              busy_ff <= 16'(RD_BUSY);
              mode_ff <= 2'd0;
            end
            8'h70, 8'h71: mode_ff <= 2'd1;
            8'h7a: begin
              mode_ff <= 2'd2;
              sect_ff <= 2'd0;
            end
            8'h80: pend_ff <= 1'b1;
            8'h10, 8'h11, 8'hd0: begin
              pend_ff <= 1'b0;
              if (wp_n_i && (pend_ff || io_i == 8'hd0)) begin
                busy_ff <= 16'(PE_BUSY);
                pe_ff <= 1'b1;
              end
            end
            8'hff: begin
              busy_ff <= 16'h0003;
              {pend_ff, pe_ff, mode_ff} <= '0;
            end
            default: ;
          endcase
        end else if (ale_i) begin
          if (acnt_ff < 3'h5) acnt_ff <= acnt_ff + 3'h1;
          if (acnt_ff == 3'h0) col_ff[7:0] <= io_i;
          if (acnt_ff == 3'h1) col_ff[11:8] <= io_i[3:0];
        end else begin
          // data bytes advance the column register by one
          col_ff <= col_ff + 12'h001;
        end
      end
      if (!rs_ff && read_strobe_n_i && !ce_n_i) begin
        last_ff <= cur;
        if (mode_ff == 2'd0) col_ff <= col_ff + 12'h001;
        if (mode_ff == 2'd2) sect_ff <= sect_ff + 2'd1;
      end
    end
  end
endmodule

// ===== bench/nch_host_tb_top.sv
// testbench for the nand command host
`timescale 1ns/10ps
`include "nch_defs.svh"
module nch_host_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, v;
  logic irq_o, cle_o, ale_o, ce_n_o, we_n_o, read_strobe_n_o, wp_n_o;
  logic io_oe_o, rb;
  logic [7:0] io_o, dev_io, io_bus;
  int num_errors = 0;
  int num_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  assign io_bus = io_oe_o ? io_o : dev_io;

  nch_host uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o), .cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o),
    .we_n_o(we_n_o), .read_strobe_n_o(read_strobe_n_o), .wp_n_o(wp_n_o),
    .io_i(io_bus), .io_o(io_o), .io_oe_o(io_oe_o),
    .ready_busy_out_i(rb));

  nch_dev_model dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cle_i(cle_o),
    .ale_i(ale_o), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .read_strobe_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .io_i(io_bus),
    .io_o(dev_io), .ready_busy_out_o(rb));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic wait_bit(input int b);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    while (s[b] !== 1'b1 && n < 200) begin
      rd(`NCH_A_STAT, s);
      n++;
    end
    chk("stat wait", {31'h0, s[b]}, 32'h1);
  endtask

  task automatic op(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    wait_bit(2);
  endtask

  task automatic cmd(input logic [7:0] c);
    op(`NCH_A_CTRL, {24'h0, c});
  endtask

  task automatic addr5(input logic [7:0] c0, input logic [7:0] pg);
    for (int i = 0; i < 5; i++) begin
      op(`NCH_A_ADDR, {24'h0, i == 0 ? c0 : (i == 2 ? pg : 8'h00)});
    end
  endtask

  task automatic refused(input logic e);
    logic [31:0] s;
    rd(`NCH_A_IRQ, s);
    chk("refused", {31'h0, s[1]}, {31'h0, e});
    chk("irq_o", {31'h0, irq_o}, {31'h0, e});
    wr(`NCH_A_IRQ, 32'hf);
  endtask

  task automatic rdb(input logic [7:0] e);
    logic [31:0] s;
    op(`NCH_A_DATA, 32'h100);
    rd(`NCH_A_DATA, s);
    chk("data byte", {24'h0, s[7:0]}, {24'h0, e});
  endtask

  task automatic prog(input logic [7:0] pg, input logic e);
    cmd(8'h80);
    addr5(8'h00, pg);
    op(`NCH_A_DATA, 32'hff);
    cmd(8'h10);
    wait_bit(0);
    refused(e);
    if (e) cmd(8'hff);
    wait_bit(0);
  endtask

  task automatic erase;
    cmd(8'h60);
    for (int i = 0; i < 3; i++) op(`NCH_A_ADDR, 32'h0);
    cmd(8'hd0);
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk("idle pins", {24'h0, ce_n_o, we_n_o, read_strobe_n_o, cle_o,
      ale_o, wp_n_o, io_oe_o, irq_o}, 32'he0);
    @(posedge clk_sys_i);
    wr(`NCH_A_MASK, 32'h2);
    cmd(8'h00);
    refused(1'b1);
    cmd(8'h70);
    refused(1'b0);
    wait_bit(0);
    cmd(8'h55);
    refused(1'b1);
    wr(`NCH_A_STAT, 32'h100);
    chk("wp_n", {31'h0, wp_n_o}, 32'h1);
    cmd(8'h70);
    rdb(8'he0);
    rd(`NCH_A_STAT, v);
    chk("status bits", {29'h0, v[7:5]}, 32'h6);
    cmd(8'h00);
    addr5(8'h03, 8'h00);
    cmd(8'h30);
    wait_bit(0);
    rdb(8'h59);
    cmd(8'h70);
    rdb(8'he0);
    cmd(8'h00);
    rdb(8'h5e);
    cmd(8'h00);
    addr5(8'h00, 8'h00);
    refused(1'b0);
    op(`NCH_A_ADDR, 32'h0);
    refused(1'b1);
    cmd(8'h30);
    wait_bit(0);
    cmd(8'h7a);
    op(`NCH_A_SECT, 32'h0);
    rd(`NCH_A_SECT, v);
    chk("sectors", {16'h0, v[15:0]}, 32'hf810);
    rd(`NCH_A_IRQ, v);
    chk("uncorr", {31'h0, v[2]}, 32'h1);
    refused(1'b0);
    for (int i = 0; i < 5; i++) prog(8'h02, i == 4);
    prog(8'h01, 1'b1);
    prog(8'h03, 1'b0);
    rd(`NCH_A_CNT, v);
    chk("last page", {26'h0, v[5:0]}, 32'h3);
    cmd(8'h80);
    cmd(8'h85);
    refused(1'b0);
    cmd(8'h60);
    refused(1'b1);
    cmd(8'hff);
    refused(1'b0);
    wait_bit(0);
    erase();
    cmd(8'h00);
    refused(1'b1);
    cmd(8'h71);
    refused(1'b0);
    cmd(8'hff);
    refused(1'b0);
    repeat (6) @(posedge clk_sys_i);
    chk("abort ready", {31'h0, rb}, 32'h1);
    erase();
    wr(`NCH_A_STAT, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    chk("wp abort", {30'h0, rb, wp_n_o}, 32'h2);
    wr(`NCH_A_STAT, 32'h300);
    erase();
    refused(1'b1);
    chk("bad erase idle", {31'h0, rb}, 32'h1);
    wr(`NCH_A_STAT, 32'h100);
    cmd(8'hff);
    wait_bit(0);
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    num_errors++;
    wrap_up();
  end
endmodule
